// >>> design/bcs_charger.sv
`timescale 1ns/1ns
`include "bcs_params.svh"

// Persistence filter: output follows input only after a steady run
module bcs_filter
  import bcs_pkg::*;
#(
  parameter int CYC = 2500
)(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        out_q;
  logic        out_d;

  // Count disagreeing samples, flip once the run is long enough
  always_comb
  begin
    cnt_d = 16'h0000;
    out_d = out_q;
    if (din != out_q)
    begin
      if (cnt_q == 16'(CYC - 1))
        out_d = din;
      else
        cnt_d = cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

module bcs_charger
  import bcs_pkg::*;
#(
  parameter int TICK_CYC = `BCS_TICK_CYC
)(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  supply_above_uvlo,
  input  wire logic                  batt_below_precharge,
  input  wire logic                  batt_at_regulation,
  input  wire logic                  current_below_term,
  input  wire logic                  batt_below_recharge,
  input  wire logic                  sense_above_cold_default,
  input  wire logic                  sense_above_cold_offset,
  input  wire logic                  cold_offset_grounded,
  input  wire logic                  sense_below_hot,
  input  wire logic                  sense_below_disable,
  input  wire logic                  timer_select_supply,
  input  wire logic                  timer_select_ground,
  input  wire logic [`BCS_OHM_W-1:0] timer_select_ohms,
  output logic                       pass_enable,
  output logic                       precharge_select,
  output logic                       cv_mode,
  output logic                       monitor_mode,
  output logic                       precharge_fault,
  output logic                       charge_status_n,
  output logic                       fault_indicator_n,
  output logic                       charger_present_n
);
  localparam int NF = `BCS_NFLAG;
  localparam int AW = `BCS_ACC_W;
  localparam int OW = `BCS_OHM_W;

  logic [NF-1:0] sync1_q;
  logic [NF-1:0] sync2_q;
  logic [OW-1:0] ohm1_q;
  logic [OW-1:0] ohm2_q;

  // Two-stage synchronisers for every comparator flag
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      ohm1_q  <= '0;
      ohm2_q  <= '0;
    end
    else
    begin
      sync1_q <= {supply_above_uvlo, batt_below_precharge,
                  batt_at_regulation, current_below_term,
                  batt_below_recharge, sense_above_cold_default,
                  sense_above_cold_offset, cold_offset_grounded,
                  sense_below_hot, sense_below_disable,
                  timer_select_supply, timer_select_ground};
      sync2_q <= sync1_q;
      ohm1_q  <= timer_select_ohms;
      ohm2_q  <= ohm1_q;
    end
  end

  logic sup_s, below_pre, at_reg, below_term, below_rech;
  logic cold_def, cold_off, cold_gnd, hot_s, dis;
  logic tsel_sup, tsel_gnd, cold_raw;
  logic sup_f, cold_f, hot_f;
  assign {sup_s, below_pre, at_reg, below_term, below_rech,
          cold_def, cold_off, cold_gnd, hot_s, dis,
          tsel_sup, tsel_gnd} = sync2_q;

  // Grounded offset input falls back to the internal ratio
  assign cold_raw = cold_gnd ? cold_def : cold_off;

  // Supply glitch filter
  bcs_filter #(.CYC(`BCS_FILT_CYC)) u_sup_filt (
    .clock (clock),
    .rst   (rst),
    .din   (sup_s),
    .dout  (sup_f)
  );
  // Persistence on both window edges keeps suspend from chattering
  bcs_filter #(.CYC(`BCS_FILT_CYC)) u_cold_filt (
    .clock (clock),
    .rst   (rst),
    .din   (cold_raw),
    .dout  (cold_f)
  );
  bcs_filter #(.CYC(`BCS_FILT_CYC)) u_hot_filt (
    .clock (clock),
    .rst   (rst),
    .din   (hot_s),
    .dout  (hot_f)
  );

  // One-second tick for the charge timer
  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic        tick;
  assign tick = (tick_q == 32'(TICK_CYC - 1));
  always_comb
  begin
    tick_d = tick ? 32'h00000000 : tick_q + 32'h00000001;
  end

  // Time limit in ohm units, clamped to the supported span
  logic [OW-1:0] lim_ohm;
  logic          timer_en;
  always_comb
  begin
    if (tsel_sup)
      lim_ohm = OW'(`BCS_H2OHM(`BCS_INT_HOURS));
    else if (ohm2_q < OW'(`BCS_H2OHM(`BCS_MIN_HOURS)))
      lim_ohm = OW'(`BCS_H2OHM(`BCS_MIN_HOURS));
    else if (ohm2_q > OW'(`BCS_H2OHM(`BCS_MAX_HOURS)))
      lim_ohm = OW'(`BCS_H2OHM(`BCS_MAX_HOURS));
    else
      lim_ohm = ohm2_q;
  end
  assign timer_en = !tsel_gnd;

  bcs_state_t    state_q, state_d;
  logic [AW-1:0] run_q, run_d, pre_q, pre_d;
  logic          charging, susp, out_on, expire, pre_over, go;

  assign charging = (state_q == BCS_PRE) || (state_q == BCS_FAST) ||
                    (state_q == BCS_CV) || (state_q == BCS_FLOAT);
  assign susp     = cold_f || hot_f;
  assign go       = sup_f && !dis && !susp;
  assign out_on   = charging && go;
  // Seconds times 3.08 compared with ohms, no divider needed
  assign expire   = run_q >= AW'(AW'(lim_ohm) * AW'(`BCS_FULL_PCT));
  assign pre_over = pre_q >= AW'(AW'(lim_ohm) * AW'(`BCS_PRE_PCT));

  // Sequencer and timer next state
  always_comb
  begin
    state_d = state_q;
    run_d   = run_q;
    pre_d   = pre_q;
    // Accumulate only on-time; saturates at expiry with timer off
    if (out_on && tick && !expire)
    begin
      run_d = run_q + AW'(`BCS_OHM_STEP_C);
      if (state_q == BCS_PRE)
        pre_d = pre_q + AW'(`BCS_OHM_STEP_C);
    end
    if (!sup_f || dis)
    begin
      state_d = BCS_IDLE;
      run_d   = '0;
      pre_d   = '0;
    end
    else if (charging && !susp && timer_en && expire)
      state_d = BCS_MON;
    else
    begin
      case (state_q)
        BCS_IDLE:
          state_d = below_pre ? BCS_PRE : BCS_FAST;
        BCS_PRE:
          if (!susp)
          begin
            if (timer_en && pre_over)
              state_d = BCS_PFLT;
            else if (!below_pre)
              state_d = BCS_FAST;
          end
        BCS_FAST:
          if (!susp)
          begin
            if (below_pre)
              state_d = BCS_PRE;
            else if (at_reg)
              state_d = BCS_CV;
          end
        BCS_CV:
          if (!susp && below_term)
            state_d = timer_en ? BCS_FLOAT : BCS_MON;
        BCS_FLOAT:
          state_d = BCS_FLOAT;
        BCS_MON:
          if (below_rech)
          begin
            run_d   = '0;
            pre_d   = '0;
            state_d = below_pre ? BCS_PRE : BCS_FAST;
          end
        BCS_PFLT:
          if (!below_pre)
            state_d = BCS_FAST;
        default:
          state_d = BCS_IDLE;
      endcase
    end
  end

  // Suspend simply holds state, so charging resumes unaided
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= BCS_IDLE;
      run_q   <= '0;
      pre_q   <= '0;
      tick_q  <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      run_q   <= run_d;
      pre_q   <= pre_d;
      tick_q  <= tick_d;
    end
  end

  // Pin level next values
  logic pass_d, psel_d, cv_d, mon_d, pflt_d, chg_n_d, flt_n_d, cp_n_d;
  logic pass_q, psel_q, cv_q, mon_q, pflt_q, chg_n_q, flt_n_q, cp_n_q;
  always_comb
  begin
    pass_d  = out_on;
    psel_d  = out_on && (state_q == BCS_PRE);
    cv_d    = out_on && ((state_q == BCS_CV) ||
                         (state_q == BCS_FLOAT));
    mon_d   = (state_q == BCS_MON);
    pflt_d  = (state_q == BCS_PFLT);
    chg_n_d = !(out_on && !below_term);
    // Disable level keeps suspend off the fault pin; the precharge fault term is not gated
    flt_n_d = !((susp && sup_f && !dis) || pflt_d);
    cp_n_d  = !sup_f;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pass_q  <= 1'b0;
      psel_q  <= 1'b0;
      cv_q    <= 1'b0;
      mon_q   <= 1'b0;
      pflt_q  <= 1'b0;
      chg_n_q <= 1'b1;
      flt_n_q <= 1'b1;
      cp_n_q  <= 1'b1;
    end
    else
    begin
      pass_q  <= pass_d;
      psel_q  <= psel_d;
      cv_q    <= cv_d;
      mon_q   <= mon_d;
      pflt_q  <= pflt_d;
      chg_n_q <= chg_n_d;
      flt_n_q <= flt_n_d;
      cp_n_q  <= cp_n_d;
    end
  end

  assign pass_enable       = pass_q;
  assign precharge_select  = psel_q;
  assign cv_mode           = cv_q;
  assign monitor_mode      = mon_q;
  assign precharge_fault   = pflt_q;
  assign charge_status_n   = chg_n_q;
  assign fault_indicator_n = flt_n_q;
  assign charger_present_n = cp_n_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence pre_timeout_s;
    state_q == BCS_PRE && timer_en && pre_over && go;
  endsequence
  sequence fault_shown_s;
    state_q == BCS_PFLT ##1 (precharge_fault && !pass_enable &&
                             !fault_indicator_n);
  endsequence

  supply_loss_a: assert property
    (!sup_f |=> state_q == BCS_IDLE && run_q == '0)
    else $error("supply loss did not reset sequencer");
  pre_select_a: assert property
    (out_on && state_q == BCS_PRE |=> precharge_select)
    else $error("precharge current not selected");
  pre_exit_a: assert property
    (state_q == BCS_PRE && go && !below_pre && !expire &&
     !(timer_en && pre_over) |=> state_q == BCS_FAST)
    else $error("precharge not left above threshold");
  cv_entry_a: assert property
    (state_q == BCS_FAST && go && !below_pre && at_reg &&
     !(timer_en && expire) |=> state_q == BCS_CV)
    else $error("constant voltage not entered");
  status_release_a: assert property
    (below_term |=> charge_status_n)
    else $error("charge status held below termination");
  float_hold_a: assert property
    (state_q == BCS_CV && go && below_term && timer_en && !expire
     |=> state_q == BCS_FLOAT)
    else $error("float charge not entered");
  term_off_a: assert property
    (state_q == BCS_CV && go && below_term && !timer_en
     |=> state_q == BCS_MON ##1 !pass_enable)
    else $error("output not off at termination");
  pre_fault_a: assert property
    (pre_timeout_s |=> fault_shown_s)
    else $error("precharge timeout fault missing");
  expire_mon_a: assert property
    (charging && go && timer_en && expire
     |=> state_q == BCS_MON ##1 monitor_mode)
    else $error("expiry did not enter monitor");
  // Outputs one edge later reflect the suspended cycle itself
  suspend_freeze_a: assert property
    (susp && sup_f && !dis && charging
     |=> run_q == $past(run_q) && !pass_enable && !fault_indicator_n)
    else $error("suspend did not freeze timer");
  disable_reset_a: assert property
    (dis |=> run_q == '0 && (fault_indicator_n || precharge_fault))
    else $error("disable did not reset timer");
  present_pin_a: assert property
    (charger_present_n == !$past(sup_f))
    else $error("charger present pin wrong");
endmodule

// >>> pkg/bcs_params.svh
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
// Clock rate and derived counts
`define BCS_CLK_MHZ       25
`define BCS_FILT_US       100
`define BCS_FILT_CYC      (`BCS_FILT_US * `BCS_CLK_MHZ)
`define BCS_TICK_S        1
`define BCS_TICK_CYC      (`BCS_TICK_S * `BCS_CLK_MHZ * 1000000)
// Charge timer scaling: 3.08 ohm per second, kept in hundredths
`define BCS_OHM_STEP_C    308
`define BCS_FULL_PCT      100
`define BCS_PRE_PCT       25
`define BCS_SEC_PER_H     3600
`define BCS_INT_HOURS     3
`define BCS_MIN_HOURS     2
`define BCS_MAX_HOURS     6
`define BCS_H2OHM(h)      ((h) * `BCS_SEC_PER_H * `BCS_OHM_STEP_C / 100)
// Widths
`define BCS_OHM_W         17
`define BCS_ACC_W         24
`define BCS_NFLAG         12
`endif

// >>> pkg/bcs_pkg.sv
package bcs_pkg;
  // Charge sequencer states
  typedef enum logic [2:0] {
    BCS_IDLE  = 3'b000,
    BCS_PRE   = 3'b001,
    BCS_FAST  = 3'b010,
    BCS_CV    = 3'b011,
    BCS_FLOAT = 3'b100,
    BCS_MON   = 3'b101,
    BCS_PFLT  = 3'b110
  } bcs_state_t;
endpackage

// >>> verif/battery_charge_sequencer_tb.sv
`timescale 1ns/1ns
`include "bcs_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module battery_charge_sequencer_tb
  import bcs_pkg::*;
;
  logic       clock, rst, plug, timer_select_supply, timer_select_ground;
  logic [1:0] rate;
  logic [4:0] therm;
  logic [`BCS_OHM_W-1:0] timer_select_ohms;
  logic supply_above_uvlo, batt_below_precharge, batt_at_regulation;
  logic current_below_term, batt_below_recharge, sense_above_cold_default;
  logic sense_above_cold_offset, cold_offset_grounded, sense_below_hot;
  logic sense_below_disable, pass_enable, precharge_select, cv_mode;
  logic monitor_mode, precharge_fault, charge_status_n, fault_indicator_n;
  logic charger_present_n;
  int   bad_count = 0;
  int   checks_done = 0;
  int   k, on, ex;
  // Window rows: offset grounded, cold dflt, cold ofs, hot, dis | pass, flt_n
  logic [6:0] rows [7] = '{7'h43, 7'h60, 7'h23, 7'h10, 7'h53, 7'h48, 7'h45};

  bcs_pack_model pack (.clock, .pass_enable, .plug, .rate, .therm,
    .supply_above_uvlo, .batt_below_precharge, .batt_at_regulation,
    .current_below_term, .batt_below_recharge, .sense_above_cold_default,
    .sense_above_cold_offset, .cold_offset_grounded, .sense_below_hot,
    .sense_below_disable);

  // Short tick keeps hour-scale timeouts inside the run
  bcs_charger #(.TICK_CYC(2)) uut (.clock, .rst, .supply_above_uvlo,
    .batt_below_precharge, .batt_at_regulation, .current_below_term,
    .batt_below_recharge, .sense_above_cold_default, .sense_above_cold_offset,
    .cold_offset_grounded, .sense_below_hot, .sense_below_disable,
    .timer_select_supply, .timer_select_ground, .timer_select_ohms,
    .pass_enable, .precharge_select, .cv_mode, .monitor_mode,
    .precharge_fault, .charge_status_n, .fault_indicator_n,
    .charger_present_n);

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // 25 MHz clock
  initial
  begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  // Whole run is near 90k cycles
  initial
  begin
    repeat (99000) @(posedge clock);
    bad_count++;
    results();
  end

  initial
  begin
    rst = 1;
    plug = 0;
    rate = 0;
    therm = 5'h10;
    timer_select_supply = 0;
    timer_select_ground = 1;
    timer_select_ohms = 17'h0;
    cyc(16);
    rst = 0;
    `CHK({pass_enable, charge_status_n, charger_present_n}, 3'h3)
    // Supply glitch shorter than the filter
    plug = 1;
    cyc(1000);
    plug = 0;
    cyc(2600);
    `CHK(charger_present_n, 1'b1)
    plug = 1;
    cyc(2490);
    `CHK(charger_present_n, 1'b1)
    cyc(30);
    `CHK({charger_present_n, pass_enable, precharge_select, charge_status_n}, 4'h6)
    rate = 1;
    for (k = 0; k < 600 && precharge_select !== 1'b0; k++) cyc(1);
    `CHK({precharge_select, pass_enable}, 2'h1)
    rate = 0;
    $display("test start done");
    // Window table, then return inside the window
    foreach (rows[i])
    begin
      therm = rows[i][6:2];
      cyc(2560);
      `CHK({pass_enable, fault_indicator_n}, rows[i][1:0])
      therm = 5'h10;
      cyc(2560);
      `CHK({pass_enable, fault_indicator_n}, 2'h3)
    end
    therm = 5'h12;
    cyc(1200);
    therm = 5'h10;
    cyc(1400);
    `CHK(pass_enable, 1'b1)
    $display("test window done");
    // Timer off: termination ends the cycle
    rate = 1;
    for (k = 0; k < 3000 && cv_mode !== 1'b1; k++) cyc(1);
    `CHK(cv_mode, 1'b1)
    for (k = 0; k < 500 && charge_status_n !== 1'b1; k++) cyc(1);
    cyc(1);
    `CHK({pass_enable, monitor_mode, charge_status_n}, 3'h3)
    timer_select_supply = 1;
    timer_select_ground = 0;
    rate = 3;
    for (k = 0; k < 500 && monitor_mode !== 1'b0; k++) cyc(1);
    rate = 1;
    cyc(2);
    `CHK(pass_enable, 1'b1)
    // Internal timer with a hot pause during float
    on = 0;
    for (k = 0; k < 30000 && monitor_mode !== 1'b1; k++)
    begin
      if (k == 1000)
        `CHK({pass_enable, cv_mode, charge_status_n}, 3'h7)
      therm = (k >= 5000 && k < 8000) ? 5'h12 : 5'h10;
      on += pass_enable;
      cyc(1);
    end
    `CHK(on >= 21588 && on <= 21612, 1'b1)
    `CHK({pass_enable, cv_mode}, 2'h0)
    $display("test timer done");
    // Precharge timeout: clamped and programmed resistor
    timer_select_supply = 0;
    for (int i = 0; i < 2; i++)
    begin
      timer_select_ohms = i ? 17'h6c48 : 17'h03e8;
      ex = i ? 4500 : 3600;
      plug = 0;
      rate = 3;
      // Long enough for the glitch filter to see the supply go
      cyc(2600);
      rate = 0;
      plug = 1;
      on = 0;
      for (k = 0; k < 12000 && precharge_fault !== 1'b1; k++)
      begin
        on += pass_enable;
        cyc(1);
      end
      `CHK(on >= ex - 10 && on <= ex + 10, 1'b1)
      `CHK({pass_enable, fault_indicator_n}, 2'h0)
      if (i == 0)
        rate = 2;
      else
        plug = 0;
      for (k = 0; k < 3000 && precharge_fault !== 1'b0; k++) cyc(1);
      `CHK(precharge_fault, 1'b0)
    end
    $display("test precharge done");
    results();
  end
endmodule

// >>> verif/bcs_pack_model.sv
`timescale 1ns/1ns
// Cell, thermistor network and adapter facing the sequencer
module bcs_pack_model (
  input  wire logic       clock,
  input  wire logic       pass_enable,
  input  wire logic       plug,
  input  wire logic [1:0] rate,
  input  wire logic [4:0] therm,
  output logic            supply_above_uvlo,
  output logic            batt_below_precharge,
  output logic            batt_at_regulation,
  output logic            current_below_term,
  output logic            batt_below_recharge,
  output logic            sense_above_cold_default,
  output logic            sense_above_cold_offset,
  output logic            cold_offset_grounded,
  output logic            sense_below_hot,
  output logic            sense_below_disable
);
  int v = 0;
  int taper = 0;

  // Rate 1 charges only while on, 2 external rise, 3 load drain
  always @(posedge clock)
  begin
    if (rate == 2'h3 && v > 0)
      v <= v - 1;
    else if (v < 1000 && (rate == 2'h2 || (rate == 2'h1 && pass_enable)))
      v <= v + 1;
    // Current decays only while held at regulation
    if (!pass_enable || v < 1000)
      taper <= 0;
    else if (taper < 60)
      taper <= taper + 1;
  end

  // Comparator levels; no current flows while the output is off
  assign supply_above_uvlo = plug;
  assign batt_below_precharge = v < 300;
  assign batt_at_regulation = v >= 1000;
  assign batt_below_recharge = v < 900;
  assign current_below_term = !pass_enable || taper >= 60;
  assign cold_offset_grounded = therm[4];
  assign sense_above_cold_default = therm[3];
  assign sense_above_cold_offset = therm[2];
  assign sense_below_hot = therm[1];
  assign sense_below_disable = therm[0];
endmodule
